// >>> rtl/input_filter.sv
// synchroniser and debounce filter for one active-low pin
`timescale 1ns/1ns
`default_nettype none

module input_filter #(
	parameter int CYCLES = 1
) (
	// clock and reset
	input  wire logic mclk,
	input  wire logic rst,
	// pin and filtered result
	input  wire logic pinIn,
	output var  logic level,
	output var  logic fall
);

	localparam int CW = $clog2(CYCLES + 1);

	typedef struct packed {
		logic          sync1;
		logic          sync2;
		logic          stable;
		logic          fall;
		logic [CW-1:0] cnt;
	} filt_s;

	filt_s s_r;
	filt_s s_nxt;

	// accept a new level only after it held for CYCLES clocks
	always_comb begin
		s_nxt = s_r;
		s_nxt.sync1 = pinIn;
		s_nxt.sync2 = s_r.sync1;
		s_nxt.fall = 1'b0;
		if (s_r.sync2 != s_r.stable) begin
			if (s_r.cnt == CW'(CYCLES - 1)) begin
				s_nxt.stable = s_r.sync2;
				s_nxt.fall = ~s_r.sync2;
				s_nxt.cnt = '0;
			end else begin
				s_nxt.cnt = s_r.cnt + 1'b1;
			end
		end else begin
			s_nxt.cnt = '0;
		end
	end

	// inactive high at reset, as an open pin with its pull-up reads
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			s_r <= '{sync1: 1'b1, sync2: 1'b1, stable: 1'b1, fall: 1'b0, cnt: '0};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign level = s_r.stable;
	assign fall  = s_r.fall;

endmodule
`default_nettype wire

// >>> rtl/module_power_state_supervisor.sv
// power-state, watchdog and thermal supervision of the module, with apb registers
`timescale 1ns/1ns
`default_nettype none

module module_power_state_supervisor #(
	parameter int DEBOUNCE_CYCLES = power_supervisor_pkg::DEBOUNCE_CYC,
	parameter int TICK_CYCLES     = power_supervisor_pkg::TICK_CYC,
	parameter int BOOT_CYCLES     = power_supervisor_pkg::BOOT_HOLD_CYC
) (
	// clock and reset
	input  wire logic                            mclk,
	input  wire logic                            rst,
	// register bus
	input  wire power_supervisor_pkg::apb_req_s  apbReq,
	output var  power_supervisor_pkg::apb_rsp_s  apbRsp,
	output var  logic                            irq,
	// carrier inputs
	input  wire logic                            power_good_in,
	input  wire logic                            power_button_n,
	input  wire logic                            reset_button_n,
	input  wire logic                            battery_low_n,
	input  wire logic                            wake_n,
	input  wire logic                            sleep_button_n,
	input  wire logic                            lid_switch_n,
	input  wire logic                            mgmt_bus_alert_n,
	input  wire logic                            watchdog_kick_n,
	input  wire logic                            alternate_boot_n,
	input  wire logic                            thermal_alarm_n,
	// processor side
	input  wire logic                            procOverheat,
	output var  logic                            moduleReset_n,
	output var  logic                            bootPeripheral,
	output var  logic                            throttle,
	// carrier outputs
	output var  logic                            suspend_ram_state_n,
	output var  logic                            soft_off_state_n,
	output var  logic                            watchdog_expired,
	output var  logic                            thermal_shutdown_n
);

	localparam int BW = $clog2(BOOT_CYCLES + 1);
	localparam int TW = $clog2(TICK_CYCLES + 1);
	localparam int EW = power_supervisor_pkg::EV_W;
	localparam int WW = power_supervisor_pkg::WDT_W;

	typedef struct packed {
		power_supervisor_pkg::pstate_e ps;
		logic [BW-1:0]                 bootCnt;
		logic [TW-1:0]                 tickCnt;
		logic [WW-1:0]                 wdCnt;
		logic [WW-1:0]                 wdTimeout;
		logic                          atx;
		logic                          wdEn;
		logic [EW-1:0]                 intStat;
		logic [EW-1:0]                 intMask;
		logic                          wdExp;
		logic                          tripN;
		logic                          throttle;
		logic                          bootPeriph;
		logic                          modRstN;
		logic                          s3N;
		logic                          s5N;
		logic                          irq;
		power_supervisor_pkg::apb_rsp_s rsp;
	} sup_s;

	sup_s s_r;
	sup_s s_nxt;

	// filtered pins: every input passes a two-flop synchroniser
	logic [power_supervisor_pkg::BTN_N-1:0] btnRaw;
	logic [power_supervisor_pkg::BTN_N-1:0] btnLvl;
	logic [power_supervisor_pkg::BTN_N-1:0] btnFall;
	logic [power_supervisor_pkg::LVL_N-1:0] lvlRaw;
	logic [power_supervisor_pkg::LVL_N-1:0] lvlLvl;
	logic [power_supervisor_pkg::LVL_N-1:0] lvlFall;

	// pins sorted active low; open optional pins float high through pull-ups
	// open means inactive
	assign btnRaw = {lid_switch_n, sleep_button_n, reset_button_n, power_button_n};
	assign lvlRaw = {~procOverheat, thermal_alarm_n, alternate_boot_n, watchdog_kick_n,
		mgmt_bus_alert_n, wake_n, battery_low_n, ~power_good_in};

	for (genvar i = 0; i < power_supervisor_pkg::BTN_N; i++) begin : g_btn
		input_filter #(
			.CYCLES (DEBOUNCE_CYCLES)
		) u_filt (
			.mclk  (mclk),
			.rst   (rst),
			.pinIn (btnRaw[i]),
			.level (btnLvl[i]),
			.fall  (btnFall[i])
		);
	end

	// levels only synchronised, no debounce delay
	for (genvar i = 0; i < power_supervisor_pkg::LVL_N; i++) begin : g_lvl
		input_filter #(
			.CYCLES (1)
		) u_filt (
			.mclk  (mclk),
			.rst   (rst),
			.pinIn (lvlRaw[i]),
			.level (lvlLvl[i]),
			.fall  (lvlFall[i])
		);
	end

	// named views of the filtered pins
	logic pgood;
	logic hot;
	logic pwrPress;
	logic rstPress;
	logic slpPress;
	logic wakePress;
	logic kickPress;
	assign pgood     = ~lvlLvl[power_supervisor_pkg::LVL_PGOOD_N];
	assign hot       = ~lvlLvl[power_supervisor_pkg::LVL_HOT_N];
	assign pwrPress  = btnFall[power_supervisor_pkg::BTN_PWR];
	assign rstPress  = btnFall[power_supervisor_pkg::BTN_RST];
	assign slpPress  = btnFall[power_supervisor_pkg::BTN_SLP] | btnFall[power_supervisor_pkg::BTN_LID];
	assign wakePress = lvlFall[power_supervisor_pkg::LVL_WAKE];
	assign kickPress = lvlFall[power_supervisor_pkg::LVL_KICK];

	// address decode, used only for the error answer; read data has its own case
	function automatic logic isMapped(input logic [power_supervisor_pkg::ADDR_W-1:0] a);
		isMapped = (a == power_supervisor_pkg::ADDR_CTRL) || (a == power_supervisor_pkg::ADDR_STATUS)
			|| (a == power_supervisor_pkg::ADDR_WDT) || (a == power_supervisor_pkg::ADDR_INT_STAT)
			|| (a == power_supervisor_pkg::ADDR_INT_MASK);
	endfunction

	// next state of the whole block
	logic          setup;
	logic          wrDone;
	logic          kick;
	logic          tick;
	logic [EW-1:0] ev;
	logic [EW-1:0] w1c;
	logic [31:0]   rd;
	always_comb begin
		s_nxt = s_r;
		ev = '0;
		w1c = '0;
		rd = 32'h0000_0000;
		setup = apbReq.psel & ~apbReq.penable;
		wrDone = apbReq.psel & apbReq.penable & s_r.rsp.pready & apbReq.pwrite;

		// apb: answer one cycle after setup, read data latched at setup
		s_nxt.rsp.pready = setup;
		s_nxt.rsp.pslverr = setup & ~isMapped(apbReq.paddr);
		unique case (apbReq.paddr)
			power_supervisor_pkg::ADDR_CTRL: begin
				rd[power_supervisor_pkg::CTRL_ATX_BIT] = s_r.atx;
				rd[power_supervisor_pkg::CTRL_WDEN_BIT] = s_r.wdEn;
			end
			power_supervisor_pkg::ADDR_STATUS: begin
				rd[power_supervisor_pkg::STAT_STATE_LSB +: 4] = s_r.ps;
				rd[power_supervisor_pkg::STAT_PERIPH_BIT] = s_r.bootPeriph;
				rd[power_supervisor_pkg::STAT_THROT_BIT] = s_r.throttle;
				rd[power_supervisor_pkg::STAT_PGOOD_BIT] = pgood;
				rd[power_supervisor_pkg::STAT_WDEXP_BIT] = s_r.wdExp;
				rd[power_supervisor_pkg::STAT_TRIP_BIT] = ~s_r.tripN;
			end
			power_supervisor_pkg::ADDR_WDT:      rd[WW-1:0] = s_r.wdTimeout;
			power_supervisor_pkg::ADDR_INT_STAT: rd[EW-1:0] = s_r.intStat;
			power_supervisor_pkg::ADDR_INT_MASK: rd[EW-1:0] = s_r.intMask;
			default: rd = 32'h0000_0000;
		endcase
		s_nxt.rsp.prdata = setup ? rd : 32'h0000_0000;

		// register writes take effect at the completing edge only
		kick = kickPress;
		if (wrDone) begin
			unique case (apbReq.paddr)
				power_supervisor_pkg::ADDR_CTRL: begin
					s_nxt.atx = apbReq.pwdata[power_supervisor_pkg::CTRL_ATX_BIT];
					s_nxt.wdEn = apbReq.pwdata[power_supervisor_pkg::CTRL_WDEN_BIT];
					kick = kickPress | apbReq.pwdata[power_supervisor_pkg::CTRL_KICK_BIT];
				end
				power_supervisor_pkg::ADDR_WDT:      s_nxt.wdTimeout = apbReq.pwdata[WW-1:0];
				power_supervisor_pkg::ADDR_INT_STAT: w1c = apbReq.pwdata[EW-1:0];
				power_supervisor_pkg::ADDR_INT_MASK: s_nxt.intMask = apbReq.pwdata[EW-1:0];
				default: ;
			endcase
		end

		// watchdog prescaler; one enable pulse per tick period
		tick = (s_r.tickCnt == TW'(TICK_CYCLES - 1));
		s_nxt.tickCnt = tick ? '0 : s_r.tickCnt + 1'b1;

		// hardware or software kick restarts the count
		if (kick || !s_r.wdEn || s_r.ps != power_supervisor_pkg::PS_WORK) begin
			s_nxt.wdCnt = '0;
			if (kick) begin
				s_nxt.wdExp = 1'b0;
			end
		end else if (tick && !s_r.wdExp) begin
			// expiry raises the output until the next kick or a loss of power-good
			if (s_r.wdCnt >= s_r.wdTimeout - 1'b1) begin
				s_nxt.wdExp = 1'b1;
				ev[power_supervisor_pkg::EV_WD_EXP] = 1'b1;
			end else begin
				s_nxt.wdCnt = s_r.wdCnt + 1'b1;
			end
		end

		// power-state sequencing
		unique case (s_r.ps)
			power_supervisor_pkg::PS_OFF: begin
				// press powers on; wake powers on; at mode never rests off
				if ((s_r.atx && pwrPress) || wakePress || !s_r.atx) begin
					s_nxt.ps = power_supervisor_pkg::PS_BOOT;
					s_nxt.bootCnt = '0;
				end
			end
			power_supervisor_pkg::PS_BOOT: begin
				if (s_r.atx && pwrPress) begin
					s_nxt.ps = power_supervisor_pkg::PS_OFF;
				// boot count runs only while power-good is seen
				end else if (!pgood) begin
					s_nxt.bootCnt = '0;
				end else if (s_r.bootCnt == BW'(BOOT_CYCLES - 1)) begin
					s_nxt.ps = power_supervisor_pkg::PS_WORK;
					// boot mode strap taken as boot completes
					s_nxt.bootPeriph = ~lvlLvl[power_supervisor_pkg::LVL_BOOTALT];
				end else begin
					s_nxt.bootCnt = s_r.bootCnt + 1'b1;
				end
			end
			power_supervisor_pkg::PS_WORK: begin
				if (s_r.atx && pwrPress) begin
					s_nxt.ps = power_supervisor_pkg::PS_OFF;
				// sleep or lid press enters sleep
				end else if (slpPress) begin
					s_nxt.ps = power_supervisor_pkg::PS_SLEEP;
				end
			end
			power_supervisor_pkg::PS_SLEEP: begin
				if (s_r.atx && pwrPress) begin
					s_nxt.ps = power_supervisor_pkg::PS_OFF;
				// press or wake returns to working
				end else if (slpPress || wakePress) begin
					s_nxt.ps = power_supervisor_pkg::PS_WORK;
				end
			end
			default: s_nxt.ps = power_supervisor_pkg::PS_OFF;
		endcase

		// reset press reruns boot, unless soft-off
		if (rstPress && s_r.ps != power_supervisor_pkg::PS_OFF) begin
			s_nxt.ps = power_supervisor_pkg::PS_BOOT;
			s_nxt.bootCnt = '0;
		end
		// lost power-good holds the module in boot
		if (!pgood && s_nxt.ps != power_supervisor_pkg::PS_OFF) begin
			s_nxt.ps = power_supervisor_pkg::PS_BOOT;
		end
		// overheating with power-good overrides all and forces soft-off
		if (hot && pgood) begin
			s_nxt.ps = power_supervisor_pkg::PS_OFF;
		end

		// outputs follow the next state so pins and state change together
		// suspend output low in sleep
		s_nxt.s3N = (s_nxt.ps != power_supervisor_pkg::PS_SLEEP);
		s_nxt.s5N = (s_nxt.ps != power_supervisor_pkg::PS_OFF);
		s_nxt.modRstN = (s_nxt.ps == power_supervisor_pkg::PS_WORK)
			|| (s_nxt.ps == power_supervisor_pkg::PS_SLEEP);
		s_nxt.throttle = ~lvlLvl[power_supervisor_pkg::LVL_THERM];
		// trip output low while the processor is hot and power-good is seen
		s_nxt.tripN = ~(hot && pgood);
		// no power-good: watchdog and trip idle
		if (!pgood) begin
			s_nxt.wdExp = 1'b0;
			s_nxt.tripN = 1'b1;
		end

		// event sources; levels keep setting while they persist
		ev[power_supervisor_pkg::EV_PWR_BTN] = pwrPress;
		ev[power_supervisor_pkg::EV_RST_BTN] = rstPress;
		ev[power_supervisor_pkg::EV_BAT_LOW] = ~lvlLvl[power_supervisor_pkg::LVL_BAT];
		ev[power_supervisor_pkg::EV_WAKE] = wakePress;
		ev[power_supervisor_pkg::EV_SLEEP] = slpPress;
		ev[power_supervisor_pkg::EV_ALERT] = ~lvlLvl[power_supervisor_pkg::LVL_ALERT];
		ev[power_supervisor_pkg::EV_THERM] = ~lvlLvl[power_supervisor_pkg::LVL_THERM];
		ev[power_supervisor_pkg::EV_TRIP] = hot && pgood;

		// sticky status: a new event beats a clear in the same cycle
		s_nxt.intStat = (s_r.intStat & ~w1c) | ev;
		s_nxt.irq = |(s_nxt.intStat & s_nxt.intMask);
	end

	// single register of all block state
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			s_r <= '{ps: power_supervisor_pkg::PS_OFF, bootCnt: '0, tickCnt: '0, wdCnt: '0,
				wdTimeout: power_supervisor_pkg::WDT_RST, atx: power_supervisor_pkg::CTRL_ATX_RST,
				wdEn: power_supervisor_pkg::CTRL_WDEN_RST, intStat: '0, intMask: '0,
				wdExp: 1'b0, tripN: 1'b1, throttle: 1'b0, bootPeriph: 1'b0, modRstN: 1'b0,
				s3N: 1'b1, s5N: 1'b0, irq: 1'b0, rsp: '0};
		end else begin
			s_r <= s_nxt;
		end
	end

	// ports straight from the state register
	assign apbRsp              = s_r.rsp;
	assign irq                 = s_r.irq;
	assign moduleReset_n       = s_r.modRstN;
	assign bootPeripheral      = s_r.bootPeriph;
	assign throttle            = s_r.throttle;
	assign suspend_ram_state_n = s_r.s3N;
	assign soft_off_state_n    = s_r.s5N;
	assign watchdog_expired    = s_r.wdExp;
	assign thermal_shutdown_n  = s_r.tripN;

	// checks beside the logic
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);

	sequence wd_last_tick;
		s_r.wdEn && pgood && !kick && s_r.ps == power_supervisor_pkg::PS_WORK && tick
			&& !s_r.wdExp && s_r.wdCnt == s_r.wdTimeout - 1'b1;
	endsequence
	sequence stays_hot;
		hot && pgood;
	endsequence

	a_boot_hold_off: assert property (s_r.ps == power_supervisor_pkg::PS_BOOT && !pgood
		|=> s_r.ps != power_supervisor_pkg::PS_WORK) else $error("work entered without power-good");
	a_atx_power_off: assert property (s_r.atx && pwrPress && !rstPress && pgood && !hot
		&& s_r.ps == power_supervisor_pkg::PS_WORK |=> s_r.ps == power_supervisor_pkg::PS_OFF)
		else $error("power press did not switch off");
	a_reset_reboot: assert property (rstPress && pgood && !hot
		&& s_r.ps != power_supervisor_pkg::PS_OFF |=> s_r.ps == power_supervisor_pkg::PS_BOOT
		&& !moduleReset_n) else $error("reset press did not reboot");
	a_battery_event: assert property (!lvlLvl[power_supervisor_pkg::LVL_BAT]
		|=> s_r.intStat[power_supervisor_pkg::EV_BAT_LOW]) else $error("battery event lost");
	a_wake_power_on: assert property (wakePress && pgood && !hot
		&& s_r.ps == power_supervisor_pkg::PS_OFF |=> s_r.ps == power_supervisor_pkg::PS_BOOT
		&& s_r.intStat[power_supervisor_pkg::EV_WAKE]) else $error("wake did not power on");
	a_s3_pin_state: assert property ((s_r.ps == power_supervisor_pkg::PS_SLEEP)
		== !suspend_ram_state_n) else $error("suspend output mismatch");
	a_s5_pin_state: assert property ((s_r.ps == power_supervisor_pkg::PS_OFF)
		== !soft_off_state_n) else $error("soft-off output mismatch");
	a_sleep_toggle: assert property (slpPress && pgood && !hot && !rstPress && !pwrPress
		&& s_r.ps == power_supervisor_pkg::PS_WORK |=> s_r.ps == power_supervisor_pkg::PS_SLEEP)
		else $error("sleep press ignored");
	a_kick_restart: assert property (kickPress |=> s_r.wdCnt == '0 && !watchdog_expired)
		else $error("kick did not restart watchdog");
	a_wd_expiry: assert property (wd_last_tick |=> watchdog_expired
		##1 $stable(s_r.wdCnt)) else $error("watchdog expiry missed");
	a_throttle_follow: assert property (!lvlLvl[power_supervisor_pkg::LVL_THERM]
		|=> throttle) else $error("throttle not raised");
	a_trip_soft_off: assert property (stays_hot |=> !thermal_shutdown_n
		&& s_r.ps == power_supervisor_pkg::PS_OFF) else $error("trip not taken");
	a_idle_no_power: assert property (!pgood[*2] |-> !watchdog_expired
		&& thermal_shutdown_n) else $error("outputs active without power-good");

endmodule
`default_nettype wire

// >>> rtl/power_supervisor_pkg.sv
// shared constants, register map and carrier types of the power-state supervisor
package power_supervisor_pkg;

	// clock and derived cycle counts
	localparam int CLK_PERIOD_NS = 8;
	localparam int DEBOUNCE_NS   = 10_000_000;
	localparam int DEBOUNCE_CYC  = DEBOUNCE_NS / CLK_PERIOD_NS;
	localparam int TICK_NS       = 1_000_000;
	localparam int TICK_CYC      = TICK_NS / CLK_PERIOD_NS;
	localparam int BOOT_HOLD_NS  = 1_000;
	localparam int BOOT_HOLD_CYC = (BOOT_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// register byte addresses
	localparam int ADDR_W = 12;
	localparam logic [ADDR_W-1:0] ADDR_CTRL     = 12'h000;
	localparam logic [ADDR_W-1:0] ADDR_STATUS   = 12'h004;
	localparam logic [ADDR_W-1:0] ADDR_WDT      = 12'h008;
	localparam logic [ADDR_W-1:0] ADDR_INT_STAT = 12'h00C;
	localparam logic [ADDR_W-1:0] ADDR_INT_MASK = 12'h010;

	// control fields and reset values
	localparam int CTRL_ATX_BIT  = 0;
	localparam int CTRL_WDEN_BIT = 1;
	localparam int CTRL_KICK_BIT = 2;
	localparam logic        CTRL_ATX_RST  = 1'h0;
	localparam logic        CTRL_WDEN_RST = 1'h0;
	localparam int          WDT_W         = 16;
	localparam logic [15:0] WDT_RST       = 16'h03E8;

	// status fields
	localparam int STAT_STATE_LSB  = 0;
	localparam int STAT_PERIPH_BIT = 4;
	localparam int STAT_THROT_BIT  = 5;
	localparam int STAT_PGOOD_BIT  = 6;
	localparam int STAT_WDEXP_BIT  = 7;
	localparam int STAT_TRIP_BIT   = 8;

	// event bits, shared by interrupt status and mask
	localparam int EV_PWR_BTN = 0;
	localparam int EV_RST_BTN = 1;
	localparam int EV_BAT_LOW = 2;
	localparam int EV_WAKE    = 3;
	localparam int EV_SLEEP   = 4;
	localparam int EV_ALERT   = 5;
	localparam int EV_WD_EXP  = 6;
	localparam int EV_THERM   = 7;
	localparam int EV_TRIP    = 8;
	localparam int EV_W       = 9;

	// filtered input indices, all active low after the filter
	localparam int BTN_PWR = 0;
	localparam int BTN_RST = 1;
	localparam int BTN_SLP = 2;
	localparam int BTN_LID = 3;
	localparam int BTN_N   = 4;
	localparam int LVL_PGOOD_N = 0;
	localparam int LVL_BAT     = 1;
	localparam int LVL_WAKE    = 2;
	localparam int LVL_ALERT   = 3;
	localparam int LVL_KICK    = 4;
	localparam int LVL_BOOTALT = 5;
	localparam int LVL_THERM   = 6;
	localparam int LVL_HOT_N   = 7;
	localparam int LVL_N       = 8;

	// power states, one-hot
	typedef enum logic [3:0] {
		PS_OFF   = 4'h1,
		PS_BOOT  = 4'h2,
		PS_WORK  = 4'h4,
		PS_SLEEP = 4'h8
	} pstate_e;

	// apb request and answer
	typedef struct packed {
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [31:0]       pwdata;
	} apb_req_s;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} apb_rsp_s;

endpackage

// >>> sim/carrier_board_model.sv
// carrier board model: supply, buttons, switches and alarm pins
`timescale 1ns/1ns
`default_nettype none

module carrier_board_model #(
	parameter int HOLD = 10
) (
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       rst,
	// requests from the bench
	input  wire logic       supplyOk,
	input  wire logic       pressReq,
	input  wire logic       levelReq,
	input  wire logic [3:0] pinSel,
	input  wire logic       levelVal,
	// pins toward the module
	output var  logic       pgood,
	output var  logic [9:0] pinN
);
	int         pressLeft;
	logic [3:0] pressPin;

	// pins change only on the clock, so the module sees clean levels
	// idle pins pulled high
	// press is a HOLD-clock low pulse, longer than the debounce
	// alert pin held as a level, any bus device may pull it
	always_ff @(posedge mclk) begin
		if (rst) begin
			pgood     <= 1'b0;
			pinN      <= 10'h3FF;
			pressLeft <= 0;
			pressPin  <= 4'h0;
		end else begin
			pgood <= supplyOk;
			if (pressReq) begin
				pinN[pinSel] <= 1'b0;
				pressPin     <= pinSel;
				pressLeft    <= HOLD;
			end else if (levelReq) begin
				pinN[pinSel] <= levelVal;
			end
			if (!pressReq && pressLeft > 0) begin
				pressLeft <= pressLeft - 1;
				if (pressLeft == 1) begin
					pinN[pressPin] <= 1'b1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// >>> sim/tb.sv
// self-checking bench of the power-state supervisor
`timescale 1ns/1ns
`default_nettype none

module tb;
	localparam int DEB = 4;
	localparam int HOLD = 10;
	localparam int SETTLE = DEB + 16;
	localparam logic [11:0] A_CT = power_supervisor_pkg::ADDR_CTRL;
	localparam logic [11:0] A_ST = power_supervisor_pkg::ADDR_STATUS;
	localparam logic [11:0] A_WD = power_supervisor_pkg::ADDR_WDT;
	localparam logic [11:0] A_IS = power_supervisor_pkg::ADDR_INT_STAT;
	localparam logic [11:0] A_IM = power_supervisor_pkg::ADDR_INT_MASK;
	logic mclk, rst, procOverheat, pgood, err;
	logic irq, modRstN, bootPeri, throttle, s3N, s5N, wdExp, tripN;
	logic supplyOk, pressReq, levelReq, levelVal;
	logic [3:0] pinSel;
	logic [9:0] pinN;
	logic [31:0] rd;
	power_supervisor_pkg::apb_req_s req;
	power_supervisor_pkg::apb_rsp_s rsp;
	int failures;
	int check_count;

	module_power_state_supervisor #(.DEBOUNCE_CYCLES(DEB), .TICK_CYCLES(8), .BOOT_CYCLES(4))
	module_power_state_supervisor_i (.mclk(mclk), .rst(rst), .apbReq(req), .apbRsp(rsp),
		.irq(irq), .power_good_in(pgood), .power_button_n(pinN[0]),
		.reset_button_n(pinN[1]), .sleep_button_n(pinN[2]), .lid_switch_n(pinN[3]),
		.battery_low_n(pinN[4]), .wake_n(pinN[5]), .mgmt_bus_alert_n(pinN[6]),
		.watchdog_kick_n(pinN[7]), .alternate_boot_n(pinN[8]), .thermal_alarm_n(pinN[9]),
		.procOverheat(procOverheat), .moduleReset_n(modRstN), .bootPeripheral(bootPeri),
		.throttle(throttle), .suspend_ram_state_n(s3N), .soft_off_state_n(s5N),
		.watchdog_expired(wdExp), .thermal_shutdown_n(tripN));

	carrier_board_model #(.HOLD(HOLD)) carrier_board_model_i (.mclk(mclk), .rst(rst),
		.supplyOk(supplyOk), .pressReq(pressReq), .levelReq(levelReq), .pinSel(pinSel),
		.levelVal(levelVal), .pgood(pgood), .pinN(pinN));

	// free-running system clock
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	// one apb transfer, held until pready is seen at an edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge mclk);
		req <= '{1'b1, 1'b0, wr, a, d};
		@(posedge mclk);
		req.penable <= 1'b1;
		// no bound of its own; the wait ends when pready is seen, else the hang guard stops the run
		do begin
			@(posedge mclk);
		end while (rsp.pready !== 1'b1);
		rd = rsp.prdata;
		err = rsp.pslverr;
		req <= '0;
	endtask

	task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			failures++;
			$display("FAIL %s expected %h seen %h", name, e, g);
		end
	endtask

	task automatic chk1(input string name, input logic e, input logic g);
		chk(name, {31'h0, e}, {31'h0, g});
	endtask

	task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk("register", e, rd);
	endtask

	// poll status until the masked field matches, bounded
	task automatic wait_stat(input logic [31:0] m, input logic [31:0] e);
		int n;
		n = 0;
		do begin
			apb(1'b0, A_ST, 32'h0);
			n++;
		end while ((rd & m) !== e && n < 200);
		chk("status", e, rd & m);
	endtask

	// partner requests: a press pulse, a pin level, the supply
	task automatic press(input int idx);
		@(posedge mclk);
		pinSel <= 4'(idx);
		pressReq <= 1'b1;
		@(posedge mclk);
		pressReq <= 1'b0;
		repeat (HOLD + 1) @(posedge mclk);
	endtask

	task automatic hold(input int idx, input logic v);
		@(posedge mclk);
		pinSel <= 4'(idx);
		levelVal <= v;
		levelReq <= 1'b1;
		@(posedge mclk);
		levelReq <= 1'b0;
	endtask

	task automatic supply(input logic v);
		@(posedge mclk);
		supplyOk <= v;
	endtask

	task automatic report_and_stop();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// main sequence
	initial begin
		rst = 1'b1;
		procOverheat = 1'b0;
		req = '0;
		{supplyOk, pressReq, levelReq, levelVal, pinSel} = '0;
		failures = 0;
		check_count = 0;
		repeat (20) @(posedge mclk);
		chk1("softoff in reset", 1'b0, s5N);
		chk1("watchdog_expired in reset", 1'b0, wdExp);
		rst <= 1'b0;
		rdchk(A_CT, 32'h0);
		rdchk(A_WD, 32'h3E8);
		rdchk(A_IM, 32'h0);
		apb(1'b0, 12'h0FC, 32'h0);
		chk1("unmapped", 1'b1, err);
		repeat (SETTLE) @(posedge mclk);
		wait_stat(32'h00F, 32'h002);
		chk1("module reset", 1'b0, modRstN);
		hold(8, 1'b0);
		supply(1'b1);
		wait_stat(32'h00F, 32'h004);
		chk1("module reset", 1'b1, modRstN);
		chk1("peripheral boot", 1'b1, bootPeri);
		hold(8, 1'b1);
		// sleep, lid and wake toggling
		press(2);
		wait_stat(32'h00F, 32'h008);
		chk1("s3 out", 1'b0, s3N);
		press(3);
		wait_stat(32'h00F, 32'h004);
		chk1("s3 out", 1'b1, s3N);
		press(2);
		wait_stat(32'h00F, 32'h008);
		press(5);
		wait_stat(32'h00F, 32'h004);
		rdchk(A_IS, 32'h018);
		apb(1'b1, A_IS, 32'h1FF);
		rdchk(A_IS, 32'h000);
		// reset press reboots and resamples the boot strap
		press(1);
		wait_stat(32'h00F, 32'h004);
		chk1("peripheral boot", 1'b0, bootPeri);
		// atx power toggling
		apb(1'b1, A_CT, 32'h1);
		press(0);
		wait_stat(32'h00F, 32'h001);
		chk1("s5 out", 1'b0, s5N);
		press(0);
		wait_stat(32'h00F, 32'h004);
		// level events, mask and interrupt line
		apb(1'b1, A_IS, 32'h1FF);
		hold(4, 1'b0);
		hold(6, 1'b0);
		repeat (SETTLE) @(posedge mclk);
		rdchk(A_IS, 32'h024);
		chk1("irq masked", 1'b0, irq);
		apb(1'b1, A_IM, 32'h004);
		repeat (2) @(posedge mclk);
		chk1("irq", 1'b1, irq);
		hold(4, 1'b1);
		hold(6, 1'b1);
		repeat (SETTLE) @(posedge mclk);
		apb(1'b1, A_IS, 32'h1FF);
		repeat (2) @(posedge mclk);
		chk1("irq cleared", 1'b0, irq);
		// watchdog expiry, pin kick, software kick, power-good loss
		apb(1'b1, A_WD, 32'h3);
		apb(1'b1, A_CT, 32'h3);
		wait_stat(32'h080, 32'h080);
		chk1("watchdog_expired", 1'b1, wdExp);
		press(7);
		wait_stat(32'h080, 32'h000);
		wait_stat(32'h080, 32'h080);
		apb(1'b1, A_CT, 32'h7);
		wait_stat(32'h080, 32'h000);
		wait_stat(32'h080, 32'h080);
		supply(1'b0);
		repeat (SETTLE) @(posedge mclk);
		chk1("watchdog_expired no pgood", 1'b0, wdExp);
		supply(1'b1);
		// thermal alarm and trip
		hold(9, 1'b0);
		wait_stat(32'h020, 32'h020);
		chk1("throttle", 1'b1, throttle);
		hold(9, 1'b1);
		procOverheat <= 1'b1;
		repeat (SETTLE) @(posedge mclk);
		chk1("trip out", 1'b0, tripN);
		chk1("s5 on trip", 1'b0, s5N);
		wait_stat(32'h00F, 32'h001);
		procOverheat <= 1'b0;
		// wake from soft-off in atx mode powers the module on
		press(5);
		wait_stat(32'h00F, 32'h004);
		report_and_stop();
	end

	// hang guard, far beyond the expected run length
	initial begin
		repeat (20000) @(posedge mclk);
		failures++;
		report_and_stop();
	end
endmodule
`default_nettype wire
